// ==== rtl/cccvp_top.sv ====
`include "cccvp_consts.svh"
`default_nettype none
module cccvp_top (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic [3:0] i_svc_req,    // request pulse per channel
   input  wire cccvp_pkg::cccvp_req_t i_svc_kind,
   input  wire logic [3:0] i_flow_stop,  // remote flow-off pulses
   input  wire logic       i_txhold_done,// holding char just left
   output logic      [3:0] o_tx_en,
   output logic      [3:0] o_rx_en,
   output logic      [3:0] o_txf_clr,
   output logic      [3:0] o_rxf_clr,
   output logic            o_sc_valid,   // special char waiting
   output logic      [7:0] o_sc_char,
   output logic      [1:0] o_sc_chan,
   output logic      [7:0] o_opt1_work,  // working copies, sel channel
   output logic      [7:0] o_opt2_work,
   output logic      [7:0] o_opt3_work,
   output logic            o_par_mode    // channel zero parallel layout
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [1:0]  chsel_q;                 // channel select pointer
   logic [7:0]  gcfg_q;                  // global config register
   logic [7:0]  cmd_q [4];               // channel command per channel
   logic [7:0]  pfx_q [4];               // local vector prefix
   logic [7:0]  opt_q [4][3];            // option registers as written
   logic [7:0]  optw_q [4][3];           // working copies
   logic [7:0]  sc_q [4][4];             // special characters
   logic [7:0]  vec_q [3];               // rx, tx, modem vectors
   logic [7:0]  fwrev_q;                 // firmware revision
   logic [7:0]  rst_cnt_q;               // full reset countdown
   cccvp_pkg::cccvp_state_t st_q;
   logic [1:0]  exe_ch_q;                // channel being executed
   logic        soft_rst;                // full-chip reset pulse
   logic [3:0]  flow_q;
   logic [7:0]  cmd;                     // command under execution
   logic        one_type;
   logic        do_chrst, do_flush, do_opt, do_send, do_ctl;
   logic [2:0]  sc_sel;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   assign cmd = cmd_q[exe_ch_q];
   assign one_type = (cmd[7:4] == 4'h8) || (cmd[7:4] == 4'h4) ||
                     (cmd[7:4] == 4'h2) || (cmd[7:4] == 4'h1);
   assign do_chrst = one_type && (cmd == 8'h80);
   assign soft_rst = (st_q == cccvp_pkg::CCCVP_EXEC) && one_type &&
                     (cmd == 8'h81);
   assign do_flush = one_type && (cmd == 8'h82);
   // option change needs a flag and bit 0 clear
   assign do_opt   = one_type && cmd[`CCCVP_BIT_OPT] && !cmd[0] &&
                     (cmd[3:1] != 3'h0);
   // special send codes one to four
   assign sc_sel   = cmd[2:0];
   assign do_send  = one_type && cmd[`CCCVP_BIT_SEND] &&
                     (cmd[4:3] == 2'h0) && (sc_sel >= 3'h1) &&
                     (sc_sel <= 3'h4);
   assign do_ctl   = one_type && cmd[`CCCVP_BIT_CTL];

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_q     <= cccvp_pkg::CCCVP_IDLE;
         exe_ch_q <= 2'h0;
      end else begin
         unique case (st_q)
            cccvp_pkg::CCCVP_IDLE: begin
               // pick the lowest channel with a pending command
               if (cmd_q[0] != 8'h00) begin
                  exe_ch_q <= 2'h0;
                  st_q     <= cccvp_pkg::CCCVP_EXEC;
               end else if (cmd_q[1] != 8'h00) begin
                  exe_ch_q <= 2'h1;
                  st_q     <= cccvp_pkg::CCCVP_EXEC;
               end else if (cmd_q[2] != 8'h00) begin
                  exe_ch_q <= 2'h2;
                  st_q     <= cccvp_pkg::CCCVP_EXEC;
               end else if (cmd_q[3] != 8'h00) begin
                  exe_ch_q <= 2'h3;
                  st_q     <= cccvp_pkg::CCCVP_EXEC;
               end
            end
            cccvp_pkg::CCCVP_EXEC: begin
               st_q <= soft_rst ? cccvp_pkg::CCCVP_FULL
                                : cccvp_pkg::CCCVP_IDLE;
            end
            cccvp_pkg::CCCVP_FULL: begin
               if (rst_cnt_q == 8'h00) st_q <= cccvp_pkg::CCCVP_IDLE;
            end
            // unused state code falls back to idle
            default: st_q <= cccvp_pkg::CCCVP_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // full reset timer and firmware revision
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rst_cnt_q <= 8'h00;
         fwrev_q   <= `CCCVP_FWREV_VAL;
      end else if (soft_rst) begin
         rst_cnt_q <= 8'(`CCCVP_RST_CYC - 1);
         fwrev_q   <= 8'h00;
      end else if (st_q == cccvp_pkg::CCCVP_FULL) begin
         rst_cnt_q <= rst_cnt_q - 8'h01;
         if (rst_cnt_q == 8'h00) fwrev_q <= `CCCVP_FWREV_VAL;
      end
   end

   // ----------------------------------------------------------------
   // host writes and per-channel state
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         chsel_q <= 2'h0;
         gcfg_q  <= 8'h00;
         for (int c = 0; c < 4; c++) begin
            cmd_q[c] <= 8'h00;
            pfx_q[c] <= 8'h00;
            for (int k = 0; k < 3; k++) begin
               opt_q[c][k]  <= 8'h00;
               optw_q[c][k] <= 8'h00;
            end
            for (int k = 0; k < 4; k++) sc_q[c][k] <= 8'h00;
         end
      end else if (soft_rst) begin
         // chip reset returns every register of this block to power-on
         chsel_q <= 2'h0;
         gcfg_q  <= 8'h00;
         for (int c = 0; c < 4; c++) begin
            cmd_q[c] <= 8'h00;
            pfx_q[c] <= 8'h00;
            for (int k = 0; k < 3; k++) begin
               opt_q[c][k]  <= 8'h00;
               optw_q[c][k] <= 8'h00;
            end
            for (int k = 0; k < 4; k++) sc_q[c][k] <= 8'h00;
         end
      end else begin
         if (st_q == cccvp_pkg::CCCVP_EXEC) begin
            for (int k = 0; k < 3; k++)
               if (do_opt && cmd[k+1])
                  optw_q[exe_ch_q][k] <= opt_q[exe_ch_q][k];
            // clear after execution, valid or not
            cmd_q[exe_ch_q] <= 8'h00;
         end
         if (i_wr) begin
            // per-channel writes go to selected channel
            unique case (i_addr)
               `CCCVP_OFF_CHSEL:  chsel_q <= i_wdata[1:0];
               `CCCVP_OFF_GCFG:   gcfg_q  <= i_wdata;
               `CCCVP_OFF_CMD:    cmd_q[chsel_q] <= i_wdata;
               `CCCVP_OFF_PREFIX: pfx_q[chsel_q] <= {i_wdata[7:3], 3'h0};
               `CCCVP_OFF_OPT1:   opt_q[chsel_q][0] <= i_wdata;
               `CCCVP_OFF_OPT2:   opt_q[chsel_q][1] <= i_wdata;
               `CCCVP_OFF_OPT3:   opt_q[chsel_q][2] <= i_wdata;
               `CCCVP_OFF_SC1:    sc_q[chsel_q][0] <= i_wdata;
               `CCCVP_OFF_SC2:    sc_q[chsel_q][1] <= i_wdata;
               `CCCVP_OFF_SC3:    sc_q[chsel_q][2] <= i_wdata;
               `CCCVP_OFF_SC4:    sc_q[chsel_q][3] <= i_wdata;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // vector registers, posted on a service request
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int v = 0; v < 3; v++) vec_q[v] <= 8'h00;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (i_svc_req[c]) begin
               unique case (i_svc_kind)
                  cccvp_pkg::CCCVP_RQ_MODEM:
                     vec_q[2] <= {pfx_q[c][7:3], `CCCVP_VT_MODEM};
                  cccvp_pkg::CCCVP_RQ_TX:
                     vec_q[1] <= {pfx_q[c][7:3], `CCCVP_VT_TX};
                  cccvp_pkg::CCCVP_RQ_RXG:
                     vec_q[0] <= {pfx_q[c][7:3], `CCCVP_VT_RX_GOOD};
                  cccvp_pkg::CCCVP_RQ_RXE:
                     vec_q[0] <= {pfx_q[c][7:3], `CCCVP_VT_RX_EXC};
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // special character: jumps the queue after the holding char
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sc_valid <= 1'b0;
         o_sc_char  <= 8'h00;
         o_sc_chan  <= 2'h0;
      end else if (soft_rst) begin
         o_sc_valid <= 1'b0;
      end else if ((st_q == cccvp_pkg::CCCVP_EXEC) && do_send) begin
         // transmitter sends this before fifo data
         o_sc_valid <= 1'b1;
         o_sc_char  <= sc_q[exe_ch_q][2'(sc_sel - 3'h1)];
         o_sc_chan  <= exe_ch_q;
      end else if (i_txhold_done) begin
         o_sc_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // per-channel control instances
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_ch
      logic hit;
      assign hit = (st_q == cccvp_pkg::CCCVP_EXEC) && (exe_ch_q == 2'(g));
      cccvp_chan u_chan (
         .i_clk       (i_clk),
         .i_reset     (i_reset),
         .i_soft_rst  (soft_rst),
         .i_chan_rst  (hit && do_chrst),
         .i_flush_tx  (hit && do_flush),
         .i_ctl       (cmd[3:0]),
         .i_ctl_go    (hit && do_ctl),
         .i_flow_stop (i_flow_stop[g]),
         .o_tx_en     (o_tx_en[g]),
         .o_rx_en     (o_rx_en[g]),
         .o_flow_stop (flow_q[g]),
         .o_txf_clr   (o_txf_clr[g]),
         .o_rxf_clr   (o_rxf_clr[g])
      );
   end

   assign o_par_mode  = gcfg_q[`CCCVP_BIT_GCFG_PAR] && (chsel_q == 2'h0);
   assign o_opt1_work = optw_q[chsel_q][0];
   assign o_opt2_work = optw_q[chsel_q][1];
   assign o_opt3_work = optw_q[chsel_q][2];

   // ----------------------------------------------------------------
   // read port, data one cycle after strobe
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            `CCCVP_OFF_CHSEL:   o_rdata <= {6'h00, chsel_q};
            `CCCVP_OFF_GCFG:    o_rdata <= gcfg_q;
            `CCCVP_OFF_CMD:     o_rdata <= cmd_q[chsel_q];
            `CCCVP_OFF_PREFIX:  o_rdata <= pfx_q[chsel_q];
            `CCCVP_OFF_OPT1:    o_rdata <= opt_q[chsel_q][0];
            `CCCVP_OFF_OPT2:    o_rdata <= opt_q[chsel_q][1];
            `CCCVP_OFF_OPT3:    o_rdata <= opt_q[chsel_q][2];
            `CCCVP_OFF_SC1:     o_rdata <= sc_q[chsel_q][0];
            `CCCVP_OFF_SC2:     o_rdata <= sc_q[chsel_q][1];
            `CCCVP_OFF_SC3:     o_rdata <= sc_q[chsel_q][2];
            `CCCVP_OFF_SC4:     o_rdata <= sc_q[chsel_q][3];
            `CCCVP_OFF_FWREV:   o_rdata <= fwrev_q;
            `CCCVP_OFF_STAT:    o_rdata <= {5'h00, flow_q[chsel_q],
                                   o_tx_en[chsel_q], o_rx_en[chsel_q]};
            `CCCVP_OFF_VEC_RX:  o_rdata <= vec_q[0];
            `CCCVP_OFF_VEC_TX:  o_rdata <= vec_q[1];
            `CCCVP_OFF_VEC_MDM: o_rdata <= vec_q[2];
            default:            o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_CMD_CLEARS: assert property (@(posedge i_clk) disable iff (i_reset)
      (st_q == cccvp_pkg::CCCVP_EXEC && !soft_rst)
      |=> (cmd_q[$past(exe_ch_q)] == 8'h00))
      else $error("command not cleared");
   AST_FW_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
      soft_rst |=> (fwrev_q == 8'h00))
      else $error("revision not cleared");
   AST_FW_BACK: assert property (@(posedge i_clk) disable iff (i_reset)
      soft_rst |-> ##[1:40] (fwrev_q != 8'h00))
      else $error("revision not restored");
   AST_CHRST: assert property (@(posedge i_clk) disable iff (i_reset)
      (st_q == cccvp_pkg::CCCVP_EXEC && do_chrst)
      |=> (!o_tx_en[$past(exe_ch_q)] && !o_rx_en[$past(exe_ch_q)]
      && o_rxf_clr[$past(exe_ch_q)]))
      else $error("channel reset incomplete");
   AST_FLUSH: assert property (@(posedge i_clk) disable iff (i_reset)
      (st_q == cccvp_pkg::CCCVP_EXEC && do_flush)
      |=> (o_txf_clr[$past(exe_ch_q)] && !o_rxf_clr[$past(exe_ch_q)]
      && $stable(o_rx_en) && $stable(o_tx_en)))
      else $error("flush touched receive side");
   AST_PFX: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_svc_req[0] && i_svc_kind == cccvp_pkg::CCCVP_RQ_TX &&
      i_svc_req[3:1] == 3'h0) |=> (vec_q[1] == {pfx_q[0][7:3], 3'h2}))
      else $error("transmit vector wrong");
   AST_FLOW: assert property (@(posedge i_clk) disable iff (i_reset)
      (g_ch[1].hit && do_ctl && cmd[3:0] != 4'h0 && !i_flow_stop[1])
      |=> !flow_q[1])
      else $error("flow stop not cleared");
   AST_PAR: assert property (@(posedge i_clk) disable iff (i_reset)
      o_par_mode |-> (chsel_q == 2'h0))
      else $error("parallel layout on wrong channel");
endmodule : cccvp_top
`default_nettype wire

// ==== common/cccvp_consts.svh ====
`ifndef CCCVP_CONSTS_SVH
`define CCCVP_CONSTS_SVH
// register offsets (byte addresses on the plain port)
`define CCCVP_OFF_CMD      8'h05
`define CCCVP_OFF_PREFIX   8'h18
`define CCCVP_OFF_CHSEL    8'h0c
`define CCCVP_OFF_GCFG     8'h4b
`define CCCVP_OFF_FWREV    8'h40
`define CCCVP_OFF_OPT1     8'h08
`define CCCVP_OFF_OPT2     8'h09
`define CCCVP_OFF_OPT3     8'h0a
`define CCCVP_OFF_SC1      8'h1a
`define CCCVP_OFF_SC2      8'h1b
`define CCCVP_OFF_SC3      8'h1c
`define CCCVP_OFF_SC4      8'h1d
`define CCCVP_OFF_STAT     8'h0e
`define CCCVP_OFF_VEC_RX   8'h41
`define CCCVP_OFF_VEC_TX   8'h42
`define CCCVP_OFF_VEC_MDM  8'h43
// command and global config field positions
`define CCCVP_BIT_RESET    7
`define CCCVP_BIT_OPT      6
`define CCCVP_BIT_SEND     5
`define CCCVP_BIT_CTL      4
`define CCCVP_BIT_GCFG_PAR 0
// vector type codes
`define CCCVP_VT_MODEM     3'h1
`define CCCVP_VT_TX        3'h2
`define CCCVP_VT_RX_GOOD   3'h3
`define CCCVP_VT_RX_EXC    3'h7
// firmware revision value (arbitrary) and full reset duration
`define CCCVP_FWREV_VAL    8'h5a
`define CCCVP_RST_NS       2000
`define CCCVP_CLK_NS       100
`define CCCVP_RST_CYC      ((`CCCVP_RST_NS + `CCCVP_CLK_NS - 1) / `CCCVP_CLK_NS)
`endif

// ==== common/cccvp_pkg.sv ====
`default_nettype none
package cccvp_pkg;
   // command processor states
   typedef enum logic [1:0] {CCCVP_IDLE, CCCVP_EXEC, CCCVP_FULL} cccvp_state_t;
   // request kinds for vector posting
   typedef enum logic [1:0] {CCCVP_RQ_MODEM, CCCVP_RQ_TX, CCCVP_RQ_RXG,
                             CCCVP_RQ_RXE} cccvp_req_t;
endpackage : cccvp_pkg
`default_nettype wire

// ==== rtl/cccvp_chan.sv ====
`include "cccvp_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// per-channel control state
// ----------------------------------------------------------------
module cccvp_chan (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_soft_rst,   // full-chip reset pulse
   input  wire logic       i_chan_rst,   // channel-only reset pulse
   input  wire logic       i_flush_tx,   // flush transmit fifo pulse
   input  wire logic [3:0] i_ctl,        // tx on, tx off, rx on, rx off
   input  wire logic       i_ctl_go,     // channel control pulse
   input  wire logic       i_flow_stop,  // remote flow-off event
   output logic            o_tx_en,
   output logic            o_rx_en,
   output logic            o_flow_stop,
   output logic            o_txf_clr,
   output logic            o_rxf_clr
);
   // ----------------------------------------------------------------
   // enables
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_tx_en <= 1'b0;
         o_rx_en <= 1'b0;
      end else if (i_soft_rst || i_chan_rst) begin
         // reset disables both directions
         o_tx_en <= 1'b0;
         o_rx_en <= 1'b0;
      end else if (i_ctl_go) begin
         // disable beats enable if both set
         if (i_ctl[2]) o_tx_en <= 1'b0;
         else if (i_ctl[3]) o_tx_en <= 1'b1;
         if (i_ctl[0]) o_rx_en <= 1'b0;
         else if (i_ctl[1]) o_rx_en <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // remote flow-off flag; host control overrides it
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_flow_stop <= 1'b0;
      end else if (i_soft_rst || i_chan_rst) begin
         o_flow_stop <= 1'b0;
      end else if (i_flow_stop) begin
         // a fresh flow-off beats a host override in the same cycle
         o_flow_stop <= 1'b1;
      end else if (i_ctl_go && (i_ctl != 4'h0)) begin
         o_flow_stop <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // fifo clear pulses to the datapath
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_txf_clr <= 1'b0;
         o_rxf_clr <= 1'b0;
      end else begin
         o_txf_clr <= i_soft_rst | i_chan_rst | i_flush_tx;
         o_rxf_clr <= i_soft_rst | i_chan_rst;
      end
   end
endmodule : cccvp_chan
`default_nettype wire

// ==== dv/cccvp_host.sv ====
`include "cccvp_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// host model: master on the register port
// ----------------------------------------------------------------
module cccvp_host (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got;   // last polled value
   // bus idle from time zero
   initial begin
      o_addr  = 8'h00;
      o_wdata = 8'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end
   // one-cycle write strobe beside address and data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_clk);
      o_wr    <= 1'b0;
   endtask : wr
   // data taken 1 ns after the edge that loads it
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      #1 d = i_rdata;
   endtask : rd
   // bounded poll; running out ends the run as a mismatch
   task automatic poll(input logic [7:0] a, input logic zero);
      for (int n = 0; n < 100; n++) begin
         rd(a, got);
         if ((got === 8'h00) == zero) return;
      end
      tb.errors++;
      tb.results();
   endtask : poll
   // write one command value, then wait for clear
   task automatic cmd(input logic [7:0] v);
      wr(`CCCVP_OFF_CMD, v);
      poll(`CCCVP_OFF_CMD, 1'b1);
   endtask : cmd
   task automatic full_reset();
      cmd(8'h81);
      poll(`CCCVP_OFF_FWREV, 1'b1);
      poll(`CCCVP_OFF_FWREV, 1'b0);
   endtask : full_reset
endmodule : cccvp_host
`default_nettype wire

// ==== dv/tb.sv ====
`include "cccvp_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// command block bench
// ----------------------------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, rst, wr, rd, hold, scv, par;
   logic [7:0] addr, wd, rdata, v, sc_char, o1, o2, o3;
   logic [3:0] svc, flow, txe, rxe, txf, rxf, txs, rxs;
   logic [1:0] sc_chan;
   cccvp_pkg::cccvp_req_t kind;
   int         errors, compares, i;
   // control commands and resulting {tx, rx} enables
   logic [7:0] ctl_c [4] = '{8'h1a, 8'h11, 8'h14, 8'h1a};
   logic [7:0] ctl_e [4] = '{8'h44, 8'h40, 8'h00, 8'h44};
   // vector register per request kind, and its type code
   logic [7:0] voff  [4] = '{`CCCVP_OFF_VEC_MDM, `CCCVP_OFF_VEC_TX,
                             `CCCVP_OFF_VEC_RX, `CCCVP_OFF_VEC_RX};
   logic [7:0] vcode [4] = '{8'h01, 8'h02, 8'h03, 8'h07};
   cccvp_top cccvp_top_inst (
      .i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_svc_req(svc),
      .i_svc_kind(kind), .i_flow_stop(flow), .i_txhold_done(hold),
      .o_tx_en(txe), .o_rx_en(rxe), .o_txf_clr(txf), .o_rxf_clr(rxf),
      .o_sc_valid(scv), .o_sc_char(sc_char), .o_sc_chan(sc_chan),
      .o_opt1_work(o1), .o_opt2_work(o2), .o_opt3_work(o3),
      .o_par_mode(par));
   cccvp_host cccvp_host_inst (
      .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wd),
      .o_wr(wr), .o_rd(rd));
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // fifo clear pulses last one cycle, so keep them sticky
   always @(posedge clk) begin
      txs <= txs | txf;
      rxs <= rxs | rxf;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      cccvp_host_inst.rd(a, v);
      chk(v, e);
   endtask : rchk
   task automatic results();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst, hold, svc, flow, txs, rxs} = {1'b1, 1'b0, 16'h0000};
      kind = cccvp_pkg::CCCVP_RQ_MODEM;
      errors = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rchk(`CCCVP_OFF_FWREV, `CCCVP_FWREV_VAL);
      rchk(`CCCVP_OFF_CMD, 8'h00);
      rchk(8'ha0, 8'h00);
      cccvp_host_inst.wr(`CCCVP_OFF_CHSEL, 8'h02);
      // each enable and disable bit, only channel two moves
      for (i = 0; i < 4; i++) begin
         cccvp_host_inst.cmd(ctl_c[i]);
         chk({txe, rxe}, ctl_e[i]);
      end
      @(posedge clk) flow <= 4'b1111;
      @(posedge clk) flow <= 4'b0000;
      rchk(`CCCVP_OFF_STAT, 8'h07);
      cccvp_host_inst.cmd(8'h12);
      rchk(`CCCVP_OFF_STAT, 8'h03);
      // flush on channel one keeps its transmitter on
      cccvp_host_inst.wr(`CCCVP_OFF_CHSEL, 8'h01);
      cccvp_host_inst.cmd(8'h18);
      cccvp_host_inst.cmd(8'h82);
      chk({txe, rxe}, 8'h64);
      chk({txs, rxs}, 8'h20);
      cccvp_host_inst.wr(`CCCVP_OFF_CHSEL, 8'h02);
      cccvp_host_inst.cmd(8'h80);
      chk({txe, rxe}, 8'h20);
      chk({txs, rxs}, 8'h64);
      // unused code, two type bits, no type bit: nothing moves
      cccvp_host_inst.cmd(8'h83);
      cccvp_host_inst.cmd(8'h58);
      cccvp_host_inst.cmd(8'h0a);
      chk({txe, rxe[3:1], scv}, 8'h20);
      chk({txs, rxs}, 8'h64);
      // option copies change only on the command
      cccvp_host_inst.wr(`CCCVP_OFF_OPT1, 8'h11);
      cccvp_host_inst.wr(`CCCVP_OFF_OPT2, 8'h22);
      cccvp_host_inst.wr(`CCCVP_OFF_OPT3, 8'h33);
      chk(o2, 8'h00);
      cccvp_host_inst.cmd(8'h44);
      chk(o1 | o2, 8'h22);
      cccvp_host_inst.cmd(8'h4a);
      chk(o1 ^ o3, 8'h22);
      // each special character, held until the holding char leaves
      for (i = 1; i <= 4; i++) begin
         cccvp_host_inst.wr(`CCCVP_OFF_SC1 + 8'(i - 1), 8'h40 + 8'(i));
         cccvp_host_inst.cmd(8'h20 | 8'(i));
         chk({scv, 5'h00, sc_chan}, 8'h82);
         chk(sc_char, 8'h40 + 8'(i));
         @(posedge clk) hold <= 1'b1;
         @(posedge clk) hold <= 1'b0;
         #1 chk({7'h00, scv}, 8'h00);
      end
      cccvp_host_inst.wr(`CCCVP_OFF_PREFIX, 8'hff);
      rchk(`CCCVP_OFF_PREFIX, 8'hf8);
      for (i = 0; i < 4; i++) begin
         // channel i^1 requests; only channel two holds a prefix
         @(posedge clk) svc <= 4'(4'h1 << (i ^ 1));
         kind <= cccvp_pkg::cccvp_req_t'(i);
         @(posedge clk) svc <= 4'b0000;
         rchk(voff[i], (i == 3 ? 8'hf8 : 8'h00) | vcode[i]);
      end
      // parallel layout only for channel zero when configured
      cccvp_host_inst.wr(`CCCVP_OFF_GCFG, 8'h01);
      #1 chk({7'h00, par}, 8'h00);
      cccvp_host_inst.wr(`CCCVP_OFF_CHSEL, 8'h00);
      #1 chk({7'h00, par}, 8'h01);
      cccvp_host_inst.full_reset();
      chk({txe | rxe, 3'h0, par}, 8'h00);
      rchk(`CCCVP_OFF_GCFG, 8'h00);
      rchk(`CCCVP_OFF_FWREV, `CCCVP_FWREV_VAL);
      results();
   end
endmodule : tb
`default_nettype wire
